/* hw/step_attenuator.sv */
// attenuator control port: serial shift register, latches and power-up behaviour
`timescale 1ns/100ps
`include "step_attenuator_defines.svh"
module step_attenuator #(
   parameter int POWERUP_CYCLES = `POWERUP_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   step_attenuator_if.device pins,
   output step_attenuator_pkg::atten_t atten_reg,
   output logic powerup_done_reg
);
   import step_attenuator_pkg::*;

   // link domain: only the shift register lives on the serial clock; the strobe is read
   // here raw, which is safe only because the controller parks the clock around it
   logic [`WORD_BITS-1:0] shift_reg;
   logic [`WORD_BITS-1:0] shift_next;

   // each stage takes its upper neighbour and the top stage takes the pin
   assign shift_next[`WORD_BITS-1] = pins.serial_data;
   genvar gi;
   for (gi = 0; gi < `WORD_BITS - 1; gi++) begin : g_shift
      assign shift_next[gi] = shift_reg[gi+1];
   end

   always_ff @(posedge pins.serial_clk or negedge resetn) begin
      if (!resetn) begin
         shift_reg <= 8'h00;
      end else if (!pins.load_strobe) begin
         shift_reg <= shift_next;
      end
   end

   // pins reach the system domain through two flip-flops
   logic mode_s1_reg, mode_s2_reg;
   logic le_s1_reg, le_s2_reg, le_prev_reg;
   atten_t par_s1_reg, par_s2_reg, par_s3_reg;
   atten_t par_word_reg;
   logic [`WORD_BITS-1:0] shift_s1_reg, shift_s2_reg;

   // rising edge of a synchronised level
   function automatic logic rising(
      input logic now_level,
      input logic old_level
   );
      return now_level && !old_level;
   endfunction

   // mode pin: which source drives the core
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_s1_reg <= 1'b0;
         mode_s2_reg <= 1'b0;
      end else begin
         mode_s1_reg <= pins.mode_select;
         mode_s2_reg <= mode_s1_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         le_s1_reg <= 1'b0;
         le_s2_reg <= 1'b0;
         le_prev_reg <= 1'b0;
      end else begin
         le_s1_reg <= pins.load_strobe;
         le_s2_reg <= le_s1_reg;
         le_prev_reg <= le_s2_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         par_s1_reg <= `ATTEN_MIN;
         par_s2_reg <= `ATTEN_MIN;
         par_s3_reg <= `ATTEN_MIN;
      end else begin
         par_s1_reg <= pins.par_lines;
         par_s2_reg <= par_s1_reg;
         par_s3_reg <= par_s2_reg;
      end
   end

   // each line is synchronised on its own, so a changing word may land torn over two
   // edges; it is taken only once it reads the same twice, at the cost of one cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         par_word_reg <= `ATTEN_MIN;
      end else if (par_s2_reg == par_s3_reg) begin
         par_word_reg <= par_s2_reg;
      end
   end

   // the shift word stands still by the time the synced strobe rises, yet it comes
   // from the link domain, so it is sampled twice before the latch reads it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         shift_s1_reg <= 8'h00;
         shift_s2_reg <= 8'h00;
      end else begin
         shift_s1_reg <= shift_reg;
         shift_s2_reg <= shift_s1_reg;
      end
   end

   logic le_rise;
   assign le_rise = rising(le_s2_reg, le_prev_reg);

   // power-up window of the direct mode
   logic [16:0] pup_cnt_reg;

   // the count stops at its end value, so the window is never reopened
   logic pup_end;
   assign pup_end = (pup_cnt_reg == 17'(POWERUP_CYCLES - 1));

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pup_cnt_reg <= 17'h0_0000;
      end else if (!powerup_done_reg && !pup_end) begin
         pup_cnt_reg <= pup_cnt_reg + 17'h0_0001;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         powerup_done_reg <= 1'b0;
      end else if (pup_end) begin
         powerup_done_reg <= 1'b1;
      end
   end

   // holding latches; the shift word is stable by the time the synced strobe rises,
   // since the controller stops the serial clock before raising it
   atten_t serial_hold_reg;
   atten_t par_hold_reg;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         serial_hold_reg <= `ATTEN_MAX;
      end else if (le_rise && mode_s2_reg) begin
         serial_hold_reg <= shift_s2_reg[`ATTEN_BITS-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         par_hold_reg <= `ATTEN_MAX;
      end else if (le_rise && !mode_s2_reg) begin
         par_hold_reg <= par_word_reg;
      end
   end

   // core source: serial latch, direct lines or parallel latch
   function automatic atten_t pick_source(
      input logic serial_mode,
      input logic strobe_high,
      input logic pup_done,
      input atten_t ser_word,
      input atten_t dir_word,
      input atten_t par_word
   );
      atten_t pick;
      pick = par_word;
      if (serial_mode) begin
         pick = ser_word;
      end else if (strobe_high) begin
         // until power-up ends the lines are not trusted, so the core is held at the maximum
         pick = pup_done ? dir_word : `ATTEN_MAX;
      end
      return pick;
   endfunction

   atten_t atten_next;

   // registered below, so the core never sees the select settle
   always_comb begin
      atten_next = pick_source(mode_s2_reg, le_s2_reg, powerup_done_reg, serial_hold_reg,
         par_word_reg, par_hold_reg);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         atten_reg <= `ATTEN_MAX;
      end else begin
         atten_reg <= atten_next;
      end
   end
endmodule // step_attenuator

/* shared/step_attenuator_defines.svh */
// timing counts, field positions and reset values of the attenuator control port
`ifndef STEP_ATTENUATOR_DEFINES_SVH
`define STEP_ATTENUATOR_DEFINES_SVH

`define SYS_CLK_MHZ 200
`define WORD_BITS 8
`define ATTEN_BITS 7
`define IGNORED_TOP_BIT 7
`define SIXTEEN_DB_BIT 6
`define QUARTER_DB_BIT 0
`define ATTEN_MAX 7'h7F
`define ATTEN_MIN 7'h00

// least times round up to whole cycles; the microsecond times need no rounding
`define T_SCLK_HALF_NS 50
`define SCLK_HALF_CYC ((`T_SCLK_HALF_NS * `SYS_CLK_MHZ + 999) / 1000)
`define T_LE_SETUP_NS 10
`define LE_SETUP_CYC ((`T_LE_SETUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define T_LE_PULSE_NS 30
`define LE_PULSE_CYC ((`T_LE_PULSE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define T_PAR_SETUP_NS 100
`define PAR_SETUP_CYC ((`T_PAR_SETUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define T_POWERUP_US 400
`define POWERUP_CYC (`T_POWERUP_US * `SYS_CLK_MHZ)
`define T_RATE_GAP_US 40
`define RATE_GAP_CYC (`T_RATE_GAP_US * `SYS_CLK_MHZ)

`endif

/* shared/step_attenuator_pkg.sv */
// types shared by both ends of the attenuator control port
package step_attenuator_pkg;
   typedef enum logic [1:0] {
      MODE_SERIAL = 2'b00,
      MODE_LATCHED = 2'b01,
      MODE_DIRECT = 2'b10
   } prog_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_SHIFT = 3'b010,
      ST_LE_WAIT = 3'b011,
      ST_LE_HIGH = 3'b100,
      ST_HOLD = 3'b101,
      ST_GAP = 3'b110
   } ctrl_state_t;

   typedef logic [6:0] atten_t;
endpackage

/* shared/step_attenuator_if.sv */
// pins between the external controller and the attenuator control port
`timescale 1ns/100ps
interface step_attenuator_if;
   logic mode_select;
   logic load_strobe;
   logic serial_clk;
   logic serial_data;
   logic [6:0] par_out;
   logic [6:0] par_oe;
   logic [6:0] par_lines;

   // an undriven parallel line reads low, as the on-chip pull-down makes it
   genvar i;
   for (i = 0; i < 7; i++) begin : g_pull
      assign par_lines[i] = par_oe[i] ? par_out[i] : 1'b0;
   end

   modport device (
      input mode_select,
      input load_strobe,
      input serial_clk,
      input serial_data,
      input par_lines
   );
   modport controller (
      output mode_select,
      output load_strobe,
      output serial_clk,
      output serial_data,
      output par_out,
      output par_oe
   );
endinterface

/* hw/step_attenuator_ctrl.sv */
// external controller that drives the attenuator control pins
`timescale 1ns/100ps
`include "step_attenuator_defines.svh"
module step_attenuator_ctrl #(
   parameter int RATE_GAP_CYCLES = `RATE_GAP_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input step_attenuator_pkg::prog_mode_t cmd_mode,
   input step_attenuator_pkg::atten_t cmd_atten,
   output logic cmd_ready_reg,
   step_attenuator_if.controller pins
);
   import step_attenuator_pkg::*;

   ctrl_state_t state_reg;
   prog_mode_t mode_reg;
   logic [`WORD_BITS-1:0] word_reg;
   logic [15:0] cnt_reg;
   logic [2:0] bit_reg;
   logic sclk_reg, sdata_reg, le_reg, sel_reg;
   atten_t par_reg;

   assign pins.serial_clk = sclk_reg;
   assign pins.serial_data = sdata_reg;
   assign pins.load_strobe = le_reg;
   assign pins.mode_select = sel_reg;
   assign pins.par_out = par_reg;
   assign pins.par_oe = 7'h7F;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         mode_reg <= MODE_SERIAL;
         word_reg <= 8'h00;
         cnt_reg <= 16'h0000;
         bit_reg <= 3'h0;
         sclk_reg <= 1'b0;
         sdata_reg <= 1'b0;
         le_reg <= 1'b0;
         sel_reg <= 1'b1;
         par_reg <= `ATTEN_MIN;
         cmd_ready_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               cmd_ready_reg <= 1'b1;
               if (cmd_valid && cmd_ready_reg) begin
                  cmd_ready_reg <= 1'b0;
                  mode_reg <= cmd_mode;
                  word_reg <= {1'b0, cmd_atten};
                  sel_reg <= (cmd_mode == MODE_SERIAL);
                  // serial mode keeps the parallel lines grounded
                  par_reg <= (cmd_mode == MODE_SERIAL) ? `ATTEN_MIN : cmd_atten;
                  le_reg <= (cmd_mode == MODE_DIRECT);
                  cnt_reg <= 16'h0000;
                  bit_reg <= 3'h0;
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_reg == 16'(`PAR_SETUP_CYC - 1)) begin
                  cnt_reg <= 16'h0000;
                  if (mode_reg == MODE_SERIAL) begin
                     sdata_reg <= word_reg[0];
                     state_reg <= ST_SHIFT;
                  end else if (mode_reg == MODE_LATCHED) begin
                     state_reg <= ST_LE_WAIT;
                  end else begin
                     state_reg <= ST_GAP;
                  end
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            ST_SHIFT: begin
               // strobe stays low while the word is shifted in
               if (cnt_reg == 16'(`SCLK_HALF_CYC - 1)) begin
                  cnt_reg <= 16'h0000;
                  sclk_reg <= !sclk_reg;
                  if (sclk_reg) begin
                     bit_reg <= bit_reg + 3'h1;
                     if (bit_reg == 3'h7) begin
                        state_reg <= ST_LE_WAIT;
                     end else begin
                        sdata_reg <= word_reg[3'(bit_reg + 3'h1)];
                     end
                  end
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            ST_LE_WAIT: begin
               if (cnt_reg == 16'(`LE_SETUP_CYC - 1)) begin
                  cnt_reg <= 16'h0000;
                  le_reg <= 1'b1;
                  state_reg <= ST_LE_HIGH;
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            ST_LE_HIGH: begin
               if (cnt_reg == 16'(`LE_PULSE_CYC - 1)) begin
                  cnt_reg <= 16'h0000;
                  le_reg <= 1'b0;
                  state_reg <= ST_HOLD;
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            ST_HOLD: begin
               // data held past the strobe fall before anything moves
               if (cnt_reg == 16'(`PAR_SETUP_CYC - 1)) begin
                  cnt_reg <= 16'h0000;
                  state_reg <= ST_GAP;
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            ST_GAP: begin
               // spaces state changes so the core never toggles too fast
               if (cnt_reg == 16'(RATE_GAP_CYCLES - 1)) begin
                  cnt_reg <= 16'h0000;
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // step_attenuator_ctrl

/* testbench/step_attenuator_assertions.sv */
// wire-level checks on the pins between controller and attenuator port
`timescale 1ns/100ps
module step_attenuator_assertions (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic mode_select,
   input wire logic load_strobe,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic [6:0] par_lines
);
   logic [3:0] rise_cnt_reg;
   logic sclk_d_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sclk_d_reg <= 1'b0;
      end else begin
         sclk_d_reg <= serial_clk;
      end
   end
   // saturates so that a runaway frame still shows as a wrong count
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rise_cnt_reg <= 4'h0;
      end else if (load_strobe) begin
         rise_cnt_reg <= 4'h0;
      end else if (serial_clk && !sclk_d_reg && rise_cnt_reg != 4'hF) begin
         rise_cnt_reg <= rise_cnt_reg + 4'h1;
      end
   end
   chk_strobe_clk_idle: assert property (serial_clk |-> !load_strobe)
      else $error("strobe high while link clock high");
   chk_sclk_high_min: assert property ($rose(serial_clk) |-> serial_clk [*6])
      else $error("link clock high phase too short");
   chk_sclk_low_min: assert property ($fell(serial_clk) |-> !serial_clk [*6])
      else $error("link clock low phase too short");
   chk_strobe_setup: assert property ($rose(serial_clk) |-> !load_strobe [*2])
      else $error("strobe too soon after link clock rise");
   chk_strobe_width: assert property ($rose(load_strobe) |-> load_strobe [*6])
      else $error("strobe pulse too short");
   chk_par_grounded: assert property (mode_select |-> par_lines == 7'h00)
      else $error("parallel lines not low in serial mode");
   chk_data_stable: assert property ($rose(serial_clk) |->
      $stable(serial_data) && serial_data == $past(serial_data, 2))
      else $error("serial data moved near link clock rise");
   chk_word_bits: assert property ($rose(load_strobe) && mode_select |->
      rise_cnt_reg == 4'h8)
      else $error("serial word not eight clocks long");
endmodule // step_attenuator_assertions

/* testbench/step_attenuator_tb.sv */
// self-checking bench joining controller and attenuator port
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin $display("[ERR] %s expected %h seen %h", nm, ex, gt); err_total++; end end
module step_attenuator_tb;
   import step_attenuator_pkg::*;
   localparam int PWR_CYC = 50;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   prog_mode_t cmd_mode = MODE_SERIAL;
   atten_t cmd_atten = 7'h00;
   logic cmd_ready_reg;
   logic powerup_done_reg;
   logic ready_d = 1'b0;
   atten_t atten_reg;
   atten_t exp_a;
   atten_t exp_q[$];
   int err_total = 0;
   int checked = 0;
   int seed = 47802;
   step_attenuator_if link_if();
   step_attenuator #(.POWERUP_CYCLES(PWR_CYC)) step_attenuator_i (.sys_clk(sys_clk),
      .resetn(resetn), .pins(link_if.device), .atten_reg(atten_reg),
      .powerup_done_reg(powerup_done_reg));
   step_attenuator_ctrl #(.RATE_GAP_CYCLES(20)) step_attenuator_ctrl_i (.sys_clk(sys_clk),
      .resetn(resetn), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .cmd_atten(cmd_atten),
      .cmd_ready_reg(cmd_ready_reg), .pins(link_if.controller));
   step_attenuator_assertions step_attenuator_assertions_i (.sys_clk(sys_clk),
      .resetn(resetn), .mode_select(link_if.mode_select), .load_strobe(link_if.load_strobe),
      .serial_clk(link_if.serial_clk), .serial_data(link_if.serial_data),
      .par_lines(link_if.par_lines));
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_ready();
      int n;
      for (n = 0; n < 4000 && cmd_ready_reg !== 1'b1; n++) @(negedge sys_clk);
      if (cmd_ready_reg !== 1'b1) begin
         err_total++;
         conclude();
      end
   endtask
   // the expected core setting is noted before the command is taken
   task automatic send(input prog_mode_t m, input atten_t a);
      int n;
      wait_ready();
      exp_q.push_back(a);
      cmd_valid = 1'b1;
      cmd_mode = m;
      cmd_atten = a;
      for (n = 0; n < 4 && cmd_ready_reg !== 1'b0; n++) @(negedge sys_clk);
      cmd_valid = 1'b0;
      if (cmd_ready_reg !== 1'b0) begin
         err_total++;
         conclude();
      end
   endtask
   // a finished sequence shows as ready rising again
   always @(negedge sys_clk) begin
      if (cmd_ready_reg === 1'b1 && ready_d !== 1'b1 && exp_q.size() > 0) begin
         exp_a = exp_q.pop_front();
         `CHK("atten_reg", exp_a, atten_reg)
      end
      ready_d <= cmd_ready_reg;
   end
   initial begin
      int i;
      repeat (5) @(negedge sys_clk);
      `CHK("atten_in_reset", 7'h7F, atten_reg)
      repeat (5) @(negedge sys_clk);
      resetn = 1'b1;
      @(negedge sys_clk);
      `CHK("powerup_early", 1'b0, powerup_done_reg)
      repeat (PWR_CYC + 4) @(negedge sys_clk);
      `CHK("powerup_late", 1'b1, powerup_done_reg)
      `CHK("atten_held", 7'h7F, atten_reg)
      $display("test 0 done");
      send(MODE_SERIAL, 7'h32);
      send(MODE_SERIAL, 7'h7F);
      send(MODE_LATCHED, 7'h01);
      send(MODE_DIRECT, 7'h40);
      send(MODE_SERIAL, 7'h00);
      $display("test 1 done");
      for (i = 0; i < 10; i++) begin
         send(prog_mode_t'(2'($unsigned($random(seed)) % 3)), atten_t'($random(seed)));
      end
      $display("test 2 done");
      wait_ready();
      @(negedge sys_clk);
      resetn = 1'b0;
      repeat (3) @(negedge sys_clk);
      `CHK("atten_rereset", 7'h7F, atten_reg)
      resetn = 1'b1;
      // let ready rise and settle before noting a new expectation
      repeat (2) @(negedge sys_clk);
      send(MODE_SERIAL, 7'h55);
      wait_ready();
      @(negedge sys_clk);
      $display("test 3 done");
      conclude();
   end
endmodule // step_attenuator_tb
